//--- design/cmra_pkg.sv
/*
  Constants and types for the cache memory request arbiter.
  Assumes a single 25 MHz arbitration clock whose falling edge is the active edge.
*/
// Operation
// - Two requests: map port and channel sub-arbiter.
// - Synchronise requests, delay map 90, channel 180 ns.
// - Map grant needs lock off, no foreign read-pause.
// - Channel grant needs lock off, no foreign read-pause.
// - Map grant always selects a map cycle.
// - Channel cycle only with channel grant, no map.
// - No grant means processor cycle by default.
// - Drive two-bit address select every cycle.
// - Sub-arbiter picks one controller, handshakes with it.
// - Read-pause owner blocks others until write starts.
// - Concurrent requests resolved from selection history.
// - Straps fix group, upper or lower pair precedence.
// - Unstrapped levels alternate, giving pseudo round-robin.
// - History updated with chosen controller at T120.
// - Cycle completion clears the cycle lock.
package cmra_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MAP_DELAY_NS = 90;
  localparam int CHAN_DELAY_NS = 180;
  // Least times round up to whole cycles.
  localparam int MAP_DELAY_CYC = (MAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAN_DELAY_CYC = (CHAN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CNT_W = 3;

  // ----------------------------------------------------------------
  // Address multiplexer select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] AMX_PROCESSOR = 2'h0;
  localparam logic [1:0] AMX_MAP = 2'h1;
  localparam logic [1:0] AMX_CHANNEL = 2'h2;

  // ----------------------------------------------------------------
  // Channel controller indices
  // ----------------------------------------------------------------
  localparam int NUM_CHANNELS = 4;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int CH_C = 2;
  localparam int CH_D = 3;

  // Cycle type selection travelling together to the cache.
  typedef struct packed {
    logic map_cycle_select;
    logic channel_cycle_select;
    logic processor_cycle_select;
    logic [1:0] addr_mux_select;
  } cmra_cycle_t;

  localparam cmra_cycle_t CYCLE_RESET = '{1'b0, 1'b0, 1'b1, AMX_PROCESSOR};

  typedef enum logic [0:0] {SUB_IDLE, SUB_HELD} cmra_sub_state_t;

endpackage : cmra_pkg

//--- design/cmra_arbiter.sv
/*
  Cache memory request arbiter: map over channels over processor, plus the
  four-way channel controller sub-arbiter with strap-controlled history priority.
  Assumes the cache timing logic supplies the cycle-done and T120 pulses on the
  same clock, and that requesters hold requests until served.
*/
`timescale 1ns/1ps
module cmra_arbiter #(
  parameter int NCH = cmra_pkg::NUM_CHANNELS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_map_request_in,
  input wire logic [NCH-1:0] i_channel_request_in,
  input wire logic [NCH-1:0] i_chan_read_pause,
  input wire logic i_map_read_pause,
  input wire logic i_cpu_read_pause,
  input wire logic i_cpu_request,
  input wire logic i_cycle_done,
  input wire logic i_t120,
  input wire logic i_group_priority_strap,
  input wire logic i_upper_pair_priority_strap,
  input wire logic i_lower_pair_priority_strap,
  output cmra_pkg::cmra_cycle_t o_cycle,
  output logic o_lock,
  output logic o_map_grant_ff,
  output logic o_channel_grant_ff,
  output logic [NCH-1:0] o_channel_controller,
  output logic o_map_done,
  output logic o_chan_done
);

  // ----------------------------------------------------------------
  // Synchronisers for pin inputs
  // ----------------------------------------------------------------
  localparam int SW = 2 * NCH + 4;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  wire [SW-1:0] pins = {i_map_request_in, i_channel_request_in, i_chan_read_pause,
    i_group_priority_strap, i_upper_pair_priority_strap, i_lower_pair_priority_strap};

  // Two stages on the active falling edge; only stage two is read.
  always_ff @(negedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire map_req_s = sync2_q[SW-1];
  wire [NCH-1:0] chan_req_s = sync2_q[SW-2 -: NCH];
  wire [NCH-1:0] chan_pause_s = sync2_q[NCH+2:3];
  wire strap_group = sync2_q[2];
  wire strap_upper = sync2_q[1];
  wire strap_lower = sync2_q[0];

  // ----------------------------------------------------------------
  // Channel sub-arbiter
  // ----------------------------------------------------------------
  cmra_pkg::cmra_sub_state_t sub_q;
  cmra_pkg::cmra_sub_state_t sub_d;
  logic [NCH-1:0] sel_q;
  logic [NCH-1:0] sel_d;
  logic b_last_q;
  logic d_last_q;
  logic cd_last_q;
  logic lock_q;
  logic map_grant_q;
  logic chan_grant_q;

  // A paused controller keeps the others out until its write has started.
  wire pause_any = |chan_pause_s;
  wire [NCH-1:0] recognised = pause_any ? (chan_req_s & chan_pause_s) : chan_req_s;

  // Straps force the history signals, fixing precedence at that level.
  wire b_last_f = b_last_q | strap_upper;
  wire d_last_f = d_last_q | strap_lower;
  wire cd_last_f = cd_last_q | strap_group;
  wire ab_any = recognised[cmra_pkg::CH_A] | recognised[cmra_pkg::CH_B];
  wire cd_any = recognised[cmra_pkg::CH_C] | recognised[cmra_pkg::CH_D];
  // Within a pair, take A when B went last or A alone; same for C and D.
  wire pick_a = recognised[cmra_pkg::CH_A] & (b_last_f | ~recognised[cmra_pkg::CH_B]);
  wire pick_c = recognised[cmra_pkg::CH_C] & (d_last_f | ~recognised[cmra_pkg::CH_D]);
  wire pick_ab = ab_any & (cd_last_f | ~cd_any);
  wire [NCH-1:0] choice = pick_ab ? {2'b00, ~pick_a, pick_a} : {~pick_c, pick_c, 2'b00};
  wire chan_served = lock_q & chan_grant_q & ~map_grant_q & i_cycle_done;
  // A request withdrawn before its grant frees the selection; stale samples cannot hold it.
  wire chan_dropped = ~|(sel_q & chan_req_s) & ~chan_grant_q;

  // A lone request wins outright; a new choice is made only when idle.
  always_comb
  begin
    sub_d = sub_q;
    sel_d = sel_q;
    case (sub_q)
      cmra_pkg::SUB_IDLE:
      begin
        if (|recognised)
        begin
          sub_d = cmra_pkg::SUB_HELD;
          sel_d = choice;
        end
      end
      cmra_pkg::SUB_HELD:
      begin
        if (chan_served || chan_dropped)
        begin
          sub_d = cmra_pkg::SUB_IDLE;
          sel_d = '0;
        end
      end
      default:
      begin
        sub_d = cmra_pkg::SUB_IDLE;
        sel_d = '0;
      end
    endcase
  end

  // History records the controller in service at T120 of its cycle.
  always_ff @(negedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sub_q <= cmra_pkg::SUB_IDLE;
      sel_q <= '0;
      b_last_q <= 1'b0;
      d_last_q <= 1'b0;
      cd_last_q <= 1'b0;
    end
    else
    begin
      sub_q <= sub_d;
      sel_q <= sel_d;
      if (i_t120 && lock_q && chan_grant_q && !map_grant_q)
      begin
        if (|sel_q[cmra_pkg::CH_B:cmra_pkg::CH_A])
        begin
          b_last_q <= sel_q[cmra_pkg::CH_B];
          cd_last_q <= 1'b0;
        end
        else
        begin
          d_last_q <= sel_q[cmra_pkg::CH_D];
          cd_last_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Request delays and top-level grants
  // ----------------------------------------------------------------
  logic [cmra_pkg::DELAY_CNT_W-1:0] map_cnt_q;
  logic [cmra_pkg::DELAY_CNT_W-1:0] chan_cnt_q;
  localparam logic [cmra_pkg::DELAY_CNT_W-1:0] MAP_TGT = cmra_pkg::DELAY_CNT_W'(cmra_pkg::MAP_DELAY_CYC);
  localparam logic [cmra_pkg::DELAY_CNT_W-1:0] CHAN_TGT = cmra_pkg::DELAY_CNT_W'(cmra_pkg::CHAN_DELAY_CYC);
  wire chan_req_int = (sub_q == cmra_pkg::SUB_HELD);
  wire map_pre = (map_cnt_q == MAP_TGT);
  wire chan_pre = (chan_cnt_q == CHAN_TGT);
  wire map_served = lock_q & map_grant_q & i_cycle_done;

  // Foreign read-pause sequences keep the map and channel sources off the cache.
  wire map_ok = ~lock_q & map_pre & ~pause_any & ~i_cpu_read_pause;
  wire chan_ok = ~lock_q & chan_pre & ~i_map_read_pause & ~i_cpu_read_pause;
  wire map_grant_d = lock_q ? (map_grant_q & ~i_cycle_done) : map_ok;
  wire chan_grant_d = lock_q ? (chan_grant_q & ~i_cycle_done) : chan_ok;
  wire start = ~lock_q & (map_ok | chan_ok | i_cpu_request);
  wire lock_d = lock_q ? ~i_cycle_done : start;

  // Map outranks channels; processor is the default.
  cmra_pkg::cmra_cycle_t cycle_d;
  assign cycle_d.map_cycle_select = map_grant_d;
  assign cycle_d.channel_cycle_select = chan_grant_d & ~map_grant_d;
  assign cycle_d.processor_cycle_select = ~map_grant_d & ~chan_grant_d;
  assign cycle_d.addr_mux_select = map_grant_d ? cmra_pkg::AMX_MAP :
    (chan_grant_d ? cmra_pkg::AMX_CHANNEL : cmra_pkg::AMX_PROCESSOR);

  // Counters restart on service so a stale synchronised request cannot regrant.
  always_ff @(negedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      map_cnt_q <= '0;
      chan_cnt_q <= '0;
      lock_q <= 1'b0;
      map_grant_q <= 1'b0;
      chan_grant_q <= 1'b0;
      o_cycle <= cmra_pkg::CYCLE_RESET;
      o_map_done <= 1'b0;
      o_chan_done <= 1'b0;
    end
    else
    begin
      map_cnt_q <= (!map_req_s || map_served) ? '0 : (map_pre ? map_cnt_q : map_cnt_q + 1'b1);
      chan_cnt_q <= (!chan_req_int || chan_served) ? '0 :
        (chan_pre ? chan_cnt_q : chan_cnt_q + 1'b1);
      lock_q <= lock_d;
      map_grant_q <= map_grant_d;
      chan_grant_q <= chan_grant_d;
      o_cycle <= cycle_d;
      o_map_done <= map_served;
      o_chan_done <= chan_served;
    end
  end

  assign o_lock = lock_q;
  assign o_map_grant_ff = map_grant_q;
  assign o_channel_grant_ff = chan_grant_q;
  assign o_channel_controller = sel_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_map_req_held;
    (map_req_s && !map_served) [*4];
  endsequence

  property p_map_priority;
    @(negedge i_clock) disable iff (i_rst)
    map_grant_q |-> o_cycle.map_cycle_select;
  endproperty
  a_map_priority: assert property (p_map_priority) else $error("map grant lost map cycle");

  property p_chan_cycle;
    @(negedge i_clock) disable iff (i_rst)
    o_cycle.channel_cycle_select |-> chan_grant_q && !map_grant_q;
  endproperty
  a_chan_cycle: assert property (p_chan_cycle) else $error("channel cycle without sole grant");

  property p_cpu_default;
    @(negedge i_clock) disable iff (i_rst)
    (!map_grant_q && !chan_grant_q) |-> o_cycle.processor_cycle_select
      && o_cycle.addr_mux_select == cmra_pkg::AMX_PROCESSOR;
  endproperty
  a_cpu_default: assert property (p_cpu_default) else $error("processor not default");

  property p_amx_map;
    @(negedge i_clock) disable iff (i_rst)
    o_cycle.map_cycle_select |-> o_cycle.addr_mux_select == cmra_pkg::AMX_MAP;
  endproperty
  a_amx_map: assert property (p_amx_map) else $error("address select wrong for map");

  property p_map_delay;
    @(negedge i_clock) disable iff (i_rst)
    $rose(map_grant_q) |-> $past(map_req_s, 2) && $past(map_req_s, 3) && !$past(lock_q);
  endproperty
  a_map_delay: assert property (p_map_delay) else $error("map granted too early");

  property p_map_block;
    @(negedge i_clock) disable iff (i_rst)
    $rose(map_grant_q) |-> !$past(pause_any) && !$past(i_cpu_read_pause);
  endproperty
  a_map_block: assert property (p_map_block) else $error("map granted during foreign pause");

  property p_chan_block;
    @(negedge i_clock) disable iff (i_rst)
    $rose(chan_grant_q) |-> !$past(i_map_read_pause) && !$past(i_cpu_read_pause);
  endproperty
  a_chan_block: assert property (p_chan_block) else $error("channel granted during pause");

  property p_lock_clear;
    @(negedge i_clock) disable iff (i_rst)
    (lock_q && i_cycle_done) |=> !lock_q && !map_grant_q && !chan_grant_q;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock held after done");

  property p_onehot_sel;
    @(negedge i_clock) disable iff (i_rst)
    chan_req_int |-> $onehot(sel_q);
  endproperty
  a_onehot_sel: assert property (p_onehot_sel) else $error("controller select not one-hot");

  property p_pause_owner;
    @(negedge i_clock) disable iff (i_rst)
    ($rose(chan_req_int) && $past(pause_any)) |-> |(sel_q & $past(chan_pause_s));
  endproperty
  a_pause_owner: assert property (p_pause_owner) else $error("foreign controller chosen in pause");

  property p_map_hold;
    @(negedge i_clock) disable iff (i_rst)
    (s_map_req_held ##0 !lock_q && !pause_any && !i_cpu_read_pause && !i_map_read_pause)
      |=> map_grant_q || $past(map_served);
  endproperty
  a_map_hold: assert property (p_map_hold) else $error("held map request not granted");

endmodule : cmra_arbiter

//--- sim/cmra_far_model.sv
/*
  Cache timing stand-in that ends each locked arbiter cycle.
  Assumes the arbiter holds o_lock high for the whole locked cycle.
*/
`timescale 1ns/1ps
module cmra_far_model #(
  parameter int DONE_AT = 14
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_lock,
  output logic o_t120,
  output logic o_cycle_done
);
  // ----------------------------------------------------------------
  // Time states
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  // The count restarts after done so a stale count never ends the next cycle early.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 4'h0;
      o_t120 <= 1'b0;
      o_cycle_done <= 1'b0;
    end
    else
    begin
      cnt_q <= (i_lock && !o_cycle_done) ? cnt_q + 4'h1 : 4'h0;
      o_t120 <= i_lock && cnt_q == 4'h2;
      o_cycle_done <= i_lock && cnt_q == 4'(DONE_AT - 1);
    end
  end
endmodule : cmra_far_model

//--- sim/cmra_arbiter_test.sv
/*
  Self-checking bench for the cache memory request arbiter.
  Assumes the cache timing stand-in ends every locked cycle.
*/
`timescale 1ns/1ps
module cmra_arbiter_test;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic map_req = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_pause = 1'b0;
  logic map_pause = 1'b0;
  logic [3:0] ch_req = 4'h0;
  logic [3:0] ch_pause = 4'h0;
  logic [2:0] strap = 3'h0;
  cmra_pkg::cmra_cycle_t cyc;
  logic lock, mgnt, cgnt, t120, done, mdone, cdone;
  logic [3:0] ctl;
  logic [3:0] sel;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  // The clock flips every half period.
  always #20 i_clock = ~i_clock;
  cmra_arbiter i_cmra_arbiter (.i_clock(i_clock), .i_rst(i_rst), .i_map_request_in(map_req),
    .i_channel_request_in(ch_req), .i_chan_read_pause(ch_pause), .i_map_read_pause(map_pause),
    .i_cpu_read_pause(cpu_pause), .i_cpu_request(cpu_req), .i_cycle_done(done),
    .i_t120(t120), .i_group_priority_strap(strap[0]), .i_upper_pair_priority_strap(strap[1]),
    .i_lower_pair_priority_strap(strap[2]), .o_cycle(cyc), .o_lock(lock),
    .o_map_grant_ff(mgnt), .o_channel_grant_ff(cgnt), .o_channel_controller(ctl),
    .o_map_done(mdone), .o_chan_done(cdone));
  cmra_far_model i_cmra_far_model (.i_clock(i_clock), .i_rst(i_rst), .i_lock(lock),
    .o_t120(t120), .o_cycle_done(done));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check_bit
  task automatic check_vec(input logic [3:0] got, input logic [3:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check_vec
  // A bounded wait, so a lock that never moves ends in a failed check.
  task automatic wait_lock(input logic v, output int n);
    n = 0;
    while (lock !== v && n < 60)
    begin
      @(posedge i_clock);
      n++;
    end
    check_bit(n < 60, 1'b1, "lock wait");
  endtask : wait_lock
  task automatic serve(input logic [3:0] req);
    int n;
    ch_req <= req;
    wait_lock(1'b1, n);
    sel = ctl;
    check_bit(cyc.channel_cycle_select, 1'b1, "channel cycle");
    check_vec({2'h0, cyc.addr_mux_select}, {2'h0, cmra_pkg::AMX_CHANNEL}, "amx");
    wait_lock(1'b0, n);
    check_bit(cdone, 1'b1, "channel done");
    ch_req <= 4'h0;
    repeat (6) @(posedge i_clock);
  endtask : serve
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    int n;
    map_req <= 1'b1;
    wait_lock(1'b1, n);
    check_bit(n == cmra_pkg::MAP_DELAY_CYC + 3, 1'b1, "map delay");
    check_bit(cyc.map_cycle_select, 1'b1, "map cycle");
    check_vec({2'h0, cyc.addr_mux_select}, {2'h0, cmra_pkg::AMX_MAP}, "amx");
    wait_lock(1'b0, n);
    check_bit(mdone, 1'b1, "map done");
    map_req <= 1'b0;
    repeat (6) @(posedge i_clock);
    $display("test map done");
  endtask : t_map
  task automatic t_prio;
    int n;
    cpu_req <= 1'b1;
    wait_lock(1'b1, n);
    check_bit(cyc.processor_cycle_select, 1'b1, "cpu cycle");
    check_vec({2'h0, cyc.addr_mux_select}, 4'h0, "amx");
    cpu_req <= 1'b0;
    map_req <= 1'b1;
    ch_req <= 4'h1;
    wait_lock(1'b0, n);
    wait_lock(1'b1, n);
    check_bit(cyc.map_cycle_select & cgnt, 1'b1, "map over channel");
    check_bit(cyc.channel_cycle_select, 1'b0, "no channel");
    wait_lock(1'b0, n);
    check_bit(mdone, 1'b1, "map served first");
    check_bit(cdone, 1'b0, "channel still waiting");
    map_req <= 1'b0;
    serve(4'h1);
    check_vec(sel, 4'h1, "controller A");
    $display("test priority done");
  endtask : t_prio
  task automatic t_refuse;
    int n;
    ch_pause <= 4'h2;
    map_req <= 1'b1;
    ch_req <= 4'h1;
    repeat (20) @(posedge i_clock);
    check_bit(lock | mgnt, 1'b0, "map refused");
    check_vec(ctl, 4'h0, "other ignored");
    map_req <= 1'b0;
    cpu_pause <= 1'b1;
    repeat (4) @(posedge i_clock);
    ch_pause <= 4'h0;
    repeat (20) @(posedge i_clock);
    check_vec(ctl, 4'h1, "first request");
    check_bit(cgnt, 1'b0, "channel refused");
    cpu_pause <= 1'b0;
    map_pause <= 1'b1;
    repeat (4) @(posedge i_clock);
    check_bit(cgnt | lock, 1'b0, "channel refused in map pause");
    map_pause <= 1'b0;
    wait_lock(1'b1, n);
    check_bit(cgnt, 1'b1, "channel granted");
    wait_lock(1'b0, n);
    ch_req <= 4'h0;
    repeat (6) @(posedge i_clock);
    ch_pause <= 4'h2;
    serve(4'h3);
    check_vec(sel, 4'h2, "pause owner served");
    ch_pause <= 4'h0;
    $display("test refusal done");
  endtask : t_refuse
  task automatic t_straps;
    strap <= 3'h7;
    repeat (6) @(posedge i_clock);
    for (int k = 0; k < 4; k++)
    begin
      serve(4'(4'hf << k));
      check_vec(sel, 4'(4'h1 << k), "strap order");
    end
    $display("test straps done");
  endtask : t_straps
  task automatic t_rr;
    logic [3:0] prev;
    strap <= 3'h0;
    repeat (6) @(posedge i_clock);
    serve(4'h3);
    for (int k = 0; k < 3; k++)
    begin
      prev = sel;
      serve(4'h3);
      check_vec(sel, prev ^ 4'h3, "alternation");
    end
    serve(4'h5);
    for (int k = 0; k < 2; k++)
    begin
      prev = sel;
      serve(4'h5);
      check_vec(sel, prev ^ 4'h5, "group alternation");
    end
    $display("test alternation done");
  endtask : t_rr
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    check_bit(cyc.processor_cycle_select & !lock, 1'b1, "reset state");
    t_map();
    t_prio();
    t_refuse();
    t_straps();
    t_rr();
    end_sim();
  end
endmodule : cmra_arbiter_test
